// >>> rtl/io_ports_cde.v
/*
  Ports C, D and E: data latches, direction registers, read multiplexing and
  pin sharing with the clock output, converter, timers and serial units.
  Assumes peripheral control bits arrive synchronous to clk_sys_i and pins
  come from outside the clock domain.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "io_ports_cde_defines.vh"
module io_ports_cde (
  input  wire               clk_sys_i,
  input  wire               sys_rst_i,
  input  wire               clk_en_i,
  input  wire [`ADDR_W-1:0] addr_i,
  input  wire [7:0]         wdata_i,
  input  wire               wr_i,
  input  wire               rd_i,
  output wire [7:0]         rdata_o,
  input  wire [5:0]         port_c_pin_i,
  output wire [5:0]         port_c_pin_o,
  output wire [5:0]         port_c_pin_oe_o,
  input  wire [7:0]         port_d_pin_i,
  output wire [7:0]         port_d_pin_o,
  output wire [7:0]         port_d_pin_oe_o,
  input  wire [7:0]         port_e_pin_i,
  output wire [7:0]         port_e_pin_o,
  output wire [7:0]         port_e_pin_oe_o,
  input  wire               sys_clk_level_i,
  input  wire [6:0]         adc_channel_owned_i,
  input  wire [7:0]         timer_d_owned_i,
  input  wire               timer_a_ext_clock_sel_i,
  input  wire               timer_b_ext_clock_sel_i,
  output wire               timer_a_ext_clock_o,
  output wire               timer_b_ext_clock_o,
  input  wire               sync_serial_enable_i,
  input  wire               sync_serial_master_sel_i,
  input  wire               sck_out_i,
  input  wire               sck_oe_i,
  input  wire               mosi_out_i,
  input  wire               mosi_oe_i,
  input  wire               miso_out_i,
  input  wire               miso_oe_i,
  output wire               sck_in_o,
  output wire               mosi_in_o,
  output wire               miso_in_o,
  output wire               slave_select_o,
  input  wire [1:0]         edge_level_select_i,
  input  wire [1:0]         timer_a_channel_pin_out_i,
  input  wire [1:0]         timer_a_channel_pin_oe_i,
  output wire [1:0]         timer_a_channel_pin_in_o,
  input  wire               async_serial_enable_i,
  input  wire               txd_i,
  output wire               rxd_o,
  output wire               clk_out_enable_o
);
  reg  [5:0] port_c_latch;
  reg  [7:0] port_c_dir;
  reg  [7:0] port_d_latch;
  reg  [7:0] port_d_dir;
  reg  [7:0] port_e_latch;
  reg  [7:0] port_e_dir;
  reg  [7:0] rdata;
  reg  [7:0] next_rdata;
  reg  [7:0] c_rd;
  reg  [7:0] d_rd;
  reg  [7:0] e_rd;
  wire [5:0] c_lvl;
  wire [7:0] d_lvl;
  wire [7:0] e_lvl;
  wire       clk_out_enable;
  wire [7:0] d_periph;
  wire [7:0] e_periph;
  wire [7:0] e_pout;
  wire [7:0] e_poe;
  wire       ss_active;
  integer    i;

  // Latch or pin per bit, depending on the direction bit
  function [7:0] dir_mux;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] lvl;
    begin
      dir_mux = (dir & latch) | (~dir & lvl);
    end
  endfunction

  pin_sync #(.W(6)) sync_c (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .pin_i     (port_c_pin_i),
    .level_o   (c_lvl)
  );

  pin_sync #(.W(8)) sync_d (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .pin_i     (port_d_pin_i),
    .level_o   (d_lvl)
  );

  pin_sync #(.W(8)) sync_e (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .pin_i     (port_e_pin_i),
    .level_o   (e_lvl)
  );

  // Data latches have no reset; direction registers do
  always @(posedge clk_sys_i) begin
    if (clk_en_i && wr_i) begin
      if (addr_i == `OFS_PORT_C_DATA) begin
        port_c_latch <= wdata_i[5:0];
      end
      if (addr_i == `OFS_PORT_D_DATA) begin
        port_d_latch <= wdata_i;
      end
      if (addr_i == `OFS_PORT_E_DATA) begin
        port_e_latch <= wdata_i;
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      port_c_dir <= `DIR_RESET;
      port_d_dir <= `DIR_RESET;
      port_e_dir <= `DIR_RESET;
    end else if (clk_en_i && wr_i) begin
      if (addr_i == `OFS_PORT_C_DIR) begin
        port_c_dir <= wdata_i & 8'hbf;
      end
      if (addr_i == `OFS_PORT_D_DIR) begin
        port_d_dir <= wdata_i;
      end
      if (addr_i == `OFS_PORT_E_DIR) begin
        port_e_dir <= wdata_i;
      end
    end
  end

  assign clk_out_enable   = port_c_dir[`PC_CLK_EN_BIT];
  assign clk_out_enable_o = clk_out_enable;

  // Port C pins
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : pc_g
      if (g == `PC_CLK_PIN) begin : clk_pin
        assign port_c_pin_o[g]    = clk_out_enable ? sys_clk_level_i : port_c_latch[g];
        assign port_c_pin_oe_o[g] = clk_out_enable | port_c_dir[g];
      end else begin : gp_pin
        assign port_c_pin_o[g]    = port_c_latch[g];
        assign port_c_pin_oe_o[g] = port_c_dir[g];
      end
    end
  endgenerate

  // Port D ownership: converter channels 0-6, timer pins, external clocks
  assign d_periph = {1'b0, adc_channel_owned_i} | timer_d_owned_i
                  | ({7'h00, timer_a_ext_clock_sel_i} << `PD_TA_CLK_PIN)
                  | ({7'h00, timer_b_ext_clock_sel_i} << `PD_TB_CLK_PIN);
  assign port_d_pin_o    = port_d_latch;
  assign port_d_pin_oe_o = port_d_dir & ~d_periph;
  assign timer_a_ext_clock_o = timer_a_ext_clock_sel_i & d_lvl[`PD_TA_CLK_PIN];
  assign timer_b_ext_clock_o = timer_b_ext_clock_sel_i & d_lvl[`PD_TB_CLK_PIN];

  // Port E ownership and peripheral drive
  assign ss_active = sync_serial_enable_i & ~sync_serial_master_sel_i;
  assign e_periph  = {{3{sync_serial_enable_i}}, ss_active, edge_level_select_i,
                      {2{async_serial_enable_i}}};
  assign e_pout = {sck_out_i, mosi_out_i, miso_out_i, 1'b0,
                   timer_a_channel_pin_out_i, 1'b0, txd_i};
  assign e_poe  = {sck_oe_i, mosi_oe_i, miso_oe_i, 1'b0,
                   timer_a_channel_pin_oe_i, 1'b0, 1'b1};

  generate
    for (g = 0; g < 8; g = g + 1) begin : pe_g
      assign port_e_pin_o[g]    = e_periph[g] ? e_pout[g] : port_e_latch[g];
      assign port_e_pin_oe_o[g] = e_periph[g] ? e_poe[g] : port_e_dir[g];
    end
  endgenerate

  assign sck_in_o                 = e_lvl[7];
  assign mosi_in_o                = e_lvl[6];
  assign miso_in_o                = e_lvl[5];
  assign slave_select_o           = ss_active ? e_lvl[4] : 1'b1;
  assign timer_a_channel_pin_in_o = e_lvl[3:2];
  assign rxd_o                    = async_serial_enable_i ? e_lvl[1] : 1'b1;

  // Read values per port
  always @* begin
    c_rd = dir_mux({2'b00, port_c_dir[5:0]}, {2'b00, port_c_latch},
                   {2'b00, c_lvl}) & `PC_IMPL_MASK;
    d_rd = dir_mux(port_d_dir, port_d_latch, d_lvl);
    for (i = 0; i < 8; i = i + 1) begin
      if (d_periph[i] && !port_d_dir[i]) begin
        d_rd[i] = 1'b0;
      end
    end
    e_rd = dir_mux(port_e_dir, port_e_latch, e_lvl);
  end

  always @* begin
    case (addr_i)
      `OFS_PORT_C_DATA: next_rdata = c_rd;
      `OFS_PORT_D_DATA: next_rdata = d_rd;
      `OFS_PORT_C_DIR:  next_rdata = port_c_dir;
      `OFS_PORT_D_DIR:  next_rdata = port_d_dir;
      `OFS_PORT_E_DATA: next_rdata = e_rd;
      `OFS_PORT_E_DIR:  next_rdata = port_e_dir;
      default:          next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata <= 8'h00;
    end else if (clk_en_i) begin
      rdata <= rd_i ? next_rdata : 8'h00;
    end
  end

  assign rdata_o = rdata;
endmodule

// >>> rtl/io_ports_cde_defines.vh
/*
  Register offsets, field positions and reset values for the port C/D/E block.
  Assumes a byte-wide register port with a 4-bit address.
*/
`ifndef IO_PORTS_CDE_DEFINES_VH
`define IO_PORTS_CDE_DEFINES_VH
`define ADDR_W          4
`define OFS_PORT_C_DATA 4'h2
`define OFS_PORT_D_DATA 4'h3
`define OFS_PORT_C_DIR  4'h6
`define OFS_PORT_D_DIR  4'h7
`define OFS_PORT_E_DATA 4'h8
`define OFS_PORT_E_DIR  4'hc
`define DIR_RESET       8'h00
`define PC_CLK_PIN      2
`define PC_CLK_EN_BIT   7
`define PC_IMPL_MASK    8'h3f
`define PD_TA_CLK_PIN   6
`define PD_TB_CLK_PIN   4
`define SYNC_STAGES     3
`endif

// >>> rtl/pin_sync.v
/*
  Three-stage pin synchroniser for a bus of pins.
  Assumes asynchronous pin inputs; a change is taken when stages two and three agree.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter W = 8
) (
  input  wire         clk_sys_i,
  input  wire         sys_rst_i,
  input  wire         clk_en_i,
  input  wire [W-1:0] pin_i,
  output wire [W-1:0] level_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  reg [W-1:0] level;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_g
      always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          s1[g]    <= 1'b0;
          s2[g]    <= 1'b0;
          s3[g]    <= 1'b0;
          level[g] <= 1'b0;
        end else if (clk_en_i) begin
          s1[g] <= pin_i[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            level[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

  assign level_o = level;
endmodule

// >>> verif/io_ports_cde_bench.sv
/* Self-checking bench for the C/D/E block. Assumes the far-side model. */
`timescale 1ns/100ps
`include "io_ports_cde_defines.vh"
module io_ports_cde_bench;
  logic              clk_sys_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, rd_q = 0, ta_clk;
  logic              tsa = 0, tsb = 0, sse = 0, ssm = 0, ase = 0;
  logic [1:0]        els = 0;
  logic [`ADDR_W-1:0] addr_i = 0;
  logic [7:0]        wdata_i = 0, rdata_o, ext_c = 0, ext_d = 0, ext_e = 0, per, tdo = 0;
  logic [7:0]        d_o, d_oe, d_pin, e_o, e_oe, e_pin;
  logic [5:0]        c_o, c_oe, c_pin;
  logic [6:0]        adc = 0;
  logic [15:0]       q[$];
  logic [31:0]       seed = 32'h06a287df;
  int                fails = 0, cmp_count = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  io_ports_cde i_io_ports_cde (.clk_sys_i, .sys_rst_i, .clk_en_i(1'b1), .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .port_c_pin_i(c_pin), .port_c_pin_o(c_o), .port_c_pin_oe_o(c_oe),
    .port_d_pin_i(d_pin), .port_d_pin_o(d_o), .port_d_pin_oe_o(d_oe), .port_e_pin_i(e_pin),
    .port_e_pin_o(e_o), .port_e_pin_oe_o(e_oe), .sys_clk_level_i(per[0]),
    .adc_channel_owned_i(adc), .timer_d_owned_i(tdo), .timer_a_ext_clock_sel_i(tsa),
    .timer_b_ext_clock_sel_i(tsb), .timer_a_ext_clock_o(ta_clk), .timer_b_ext_clock_o(),
    .sync_serial_enable_i(sse), .sync_serial_master_sel_i(ssm), .sck_out_i(per[1]),
    .sck_oe_i(per[2]), .mosi_out_i(per[3]), .mosi_oe_i(per[4]), .miso_out_i(per[5]),
    .miso_oe_i(per[6]), .sck_in_o(), .mosi_in_o(), .miso_in_o(), .slave_select_o(),
    .edge_level_select_i(els), .timer_a_channel_pin_out_i(per[2:1]),
    .timer_a_channel_pin_oe_i(per[4:3]), .timer_a_channel_pin_in_o(),
    .async_serial_enable_i(ase), .txd_i(per[7]), .rxd_o(), .clk_out_enable_o());
  io_ports_cde_far i_io_ports_cde_far (.clk_sys_i, .ext_c_i(ext_c), .ext_d_i(ext_d),
    .ext_e_i(ext_e), .d_o_i(d_o), .d_oe_i(d_oe), .e_o_i(e_o), .e_oe_i(e_oe), .c_o_i(c_o),
    .c_oe_i(c_oe), .c_pin_o(c_pin), .d_pin_o(d_pin), .e_pin_o(e_pin), .per_o(per));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clk_sys_i);
    wr_i <= 0;
  endtask
  task automatic rdx(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] msk);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1;
    q.push_back({msk, exp});
    @(posedge clk_sys_i);
    rd_i <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    rd_q <= rd_i;
    if (rd_q) begin
      check(rdata_o & q[0][15:8], q[0][7:0] & q[0][15:8]);
      void'(q.pop_front());
    end
  end
  task automatic rst_dirs();
    sys_rst_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 0;
    rdx(`OFS_PORT_C_DIR, 8'h00, 8'hff);
    rdx(`OFS_PORT_D_DIR, 8'h00, 8'hff);
    rdx(`OFS_PORT_E_DIR, 8'h00, 8'hff);
    rdx(4'h1, 8'h00, 8'hff);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    logic [7:0] lc, ld, le, dc, dd, de, xc, xd, xe, p, a7, t8, od;
    rst_dirs();
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      {lc, ld, le, dc, dd, de, xc, xd, xe, p, a7, t8} = {rnd(), rnd(), rnd(), rnd(), rnd(),
        rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      {tsa, tsb, sse, ssm, ase, els} <= p[6:0];
      adc <= a7[6:0];
      tdo <= t8;
      {ext_c, ext_d, ext_e} <= {xc, xd, xe};
      od = {1'b0, a7[6:0]} | t8 | {1'b0, p[6], 1'b0, p[5], 4'h0};
      wr(`OFS_PORT_C_DATA, lc);
      wr(`OFS_PORT_D_DATA, ld);
      wr(`OFS_PORT_E_DATA, le);
      wr(`OFS_PORT_C_DIR, dc);
      wr(`OFS_PORT_D_DIR, dd);
      wr(`OFS_PORT_E_DIR, de);
      repeat (6) @(posedge clk_sys_i);
      check({2'b00, c_oe}, {2'b00, dc[5:0]} | {5'h00, dc[7], 2'b00});
      check(d_oe, dd & ~(od | {1'b0, p[6], 1'b0, p[5], 4'h0}));
      check({7'h00, ta_clk & p[6]}, {7'h00, xd[6] & p[6]});
      rdx(`OFS_PORT_C_DATA, ((dc & lc) | (~dc & xc)) & 8'h3f,
        (dc[7] && !dc[2]) ? 8'hfb : 8'hff);
      rdx(`OFS_PORT_D_DATA, (dd & ld) | (~dd & xd & ~od), 8'hff);
      rdx(`OFS_PORT_E_DATA, (de & le) | (~de & xe),
        ~({{3{p[4]}}, 1'b0, p[1:0], 1'b0, p[2]} & ~de));
      rdx(`OFS_PORT_C_DIR, dc & 8'hbf, 8'hff);
      rdx(`OFS_PORT_D_DIR, dd, 8'hff);
      rdx(`OFS_PORT_E_DIR, de, 8'hff);
    end
    $display("test random done");
    rst_dirs();
    wr(`OFS_PORT_C_DIR, 8'h3f);
    rdx(`OFS_PORT_C_DATA, lc & 8'h3f, 8'hff);
    $display("test second reset done");
    for (int k = 0; k < 10 && q.size() != 0; k++) @(posedge clk_sys_i);
    if (q.size() != 0) fails++;
    summarize();
  end
endmodule

// >>> verif/io_ports_cde_checker.sv
/* Port checks for the C/D/E block. Assumes clk_en_i held high. */
`timescale 1ns/100ps
module io_ports_cde_checker (
  input logic       clk_sys_i, sys_rst_i, sys_clk_level_i, clk_out_enable_o, txd_i,
  input logic       timer_a_ext_clock_sel_i, async_serial_enable_i, rxd_o, sck_out_i,
  input logic       sync_serial_enable_i, sync_serial_master_sel_i, slave_select_o, sck_oe_i,
  input logic [1:0] edge_level_select_i, timer_a_channel_pin_oe_i,
  input logic [5:0] port_c_pin_o, port_c_pin_oe_o,
  input logic [6:0] adc_channel_owned_i,
  input logic [7:0] port_d_pin_oe_o, port_e_pin_o, port_e_pin_oe_o, timer_d_owned_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_clk_pin: assert property (clk_out_enable_o |-> port_c_pin_oe_o[2] &&
    port_c_pin_o[2] == sys_clk_level_i) else $error("clock pin");
  a_dir_reset: assert property ($past(sys_rst_i) |-> port_c_pin_oe_o == 6'h00 &&
    port_d_pin_oe_o == 8'h00 && !clk_out_enable_o) else $error("reset dir");
  a_owned_d_hiz: assert property ((port_d_pin_oe_o &
    (timer_d_owned_i | {1'b0, adc_channel_owned_i})) == 8'h00) else $error("owned d");
  a_ext_clk_in: assert property (timer_a_ext_clock_sel_i |-> !port_d_pin_oe_o[6])
    else $error("ext clk");
  a_txd_out: assert property (async_serial_enable_i |-> port_e_pin_oe_o[0] &&
    port_e_pin_o[0] == txd_i) else $error("txd");
  a_rxd_idle: assert property (!async_serial_enable_i [*2] |-> rxd_o) else $error("rxd");
  a_ss_idle: assert property ((!sync_serial_enable_i || sync_serial_master_sel_i) [*2]
    |-> slave_select_o) else $error("ss");
  a_sck_pin: assert property (sync_serial_enable_i |-> port_e_pin_oe_o[7] == sck_oe_i &&
    (!sck_oe_i || port_e_pin_o[7] == sck_out_i)) else $error("sck");
  a_timer_a_channel_pin_pin: assert property (edge_level_select_i[0] |->
    port_e_pin_oe_o[2] == timer_a_channel_pin_oe_i[0]) else $error("timer_a_channel_pin");
  c_clk: cover property (clk_out_enable_o);
  c_slave: cover property (sync_serial_enable_i && !sync_serial_master_sel_i);
  c_async: cover property (async_serial_enable_i);
endmodule
bind io_ports_cde io_ports_cde_checker i_chk (.clk_sys_i, .sys_rst_i, .sys_clk_level_i,
  .clk_out_enable_o, .txd_i, .timer_a_ext_clock_sel_i, .async_serial_enable_i, .rxd_o,
  .sck_out_i, .sync_serial_enable_i, .sync_serial_master_sel_i, .slave_select_o, .sck_oe_i,
  .edge_level_select_i, .timer_a_channel_pin_oe_i, .port_c_pin_o, .port_c_pin_oe_o,
  .adc_channel_owned_i, .port_d_pin_oe_o, .port_e_pin_o, .port_e_pin_oe_o, .timer_d_owned_i);

// >>> verif/io_ports_cde_far.sv
/* Board and peripheral side. Assumes the bench sets the board levels. */
`timescale 1ns/100ps
module io_ports_cde_far (
  input  logic       clk_sys_i,
  input  logic [7:0] ext_c_i, ext_d_i, ext_e_i, d_o_i, d_oe_i, e_o_i, e_oe_i,
  input  logic [5:0] c_o_i, c_oe_i,
  output logic [5:0] c_pin_o,
  output logic [7:0] d_pin_o, e_pin_o, per_o
);
  logic [7:0] cnt = 8'h00;
  always @(posedge clk_sys_i) cnt <= cnt + 8'h01;
  // A driven pin shows its driver, a released one the board level
  assign c_pin_o = (c_oe_i & c_o_i) | (~c_oe_i & ext_c_i[5:0]);
  assign d_pin_o = (d_oe_i & d_o_i) | (~d_oe_i & ext_d_i);
  assign e_pin_o = (e_oe_i & e_o_i) | (~e_oe_i & ext_e_i);
  // Peripheral units change their drive every cycle except when cnt steps from 8'h7f to 8'h80 or wraps from 8'hff to 8'h00
  assign per_o = cnt ^ {cnt[3:0], cnt[7:4]};
endmodule
